// File: rtl/bcrp_pkg.sv
// constants and types for the bus clock and reset pin block
`default_nettype none
package bcrp_pkg;
	// crystal ticks per bus phase clock cycle
	localparam int unsigned CRYSTAL_DRIVE_PIN_DIV = 4;
	// phase counter width
	localparam int unsigned PH_W = 2;
	// first quarter of the access (high) half
	localparam logic [PH_W-1:0] PH_HIGH_START = 2'h2;
	// bus cycles the pin is held low for an internal reset
	localparam logic [7:0] HOLD_CYCLES = 8'h10;
	// bus cycles allowed for the pin to rise after release
	localparam logic [7:0] RISE_CYCLES = 8'h04;
	// reset values
	localparam logic [PH_W-1:0] PH_RST = 2'h0;
	localparam logic [7:0] CNT_RST = 8'h00;

	// reset sequencer states
	typedef enum logic [1:0] {
		BCRP_RUN,
		BCRP_HOLD,
		BCRP_SAMPLE,
		BCRP_EXT
	} bcrp_state_t;
endpackage : bcrp_pkg
`default_nettype wire

// File: rtl/bcrp_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none
module bcrp_sync
	import bcrp_pkg::*;
(
	// clock
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// data
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic s1;
		logic s2;
	} bcrp_sync_t;
	bcrp_sync_t r_q;
	bcrp_sync_t r_d;

	// shift chain, first stage read only by the second
	always_comb
	begin
		r_d = r_q;
		r_d.s1 = din;
		r_d.s2 = r_q.s1;
	end

	// register, idles high like the reset pin
	always_ff @(posedge clk)
	begin
		if (!rstn)
			r_q <= '{s1: 1'b1, s2: 1'b1};
		else if (ce)
			r_q <= r_d;
	end

	assign dout = r_q.s2;
endmodule : bcrp_sync
`default_nettype wire

// File: rtl/bcrp_top.sv
// bus phase clock generator and bidirectional reset pin control
`default_nettype none
module bcrp_top
	import bcrp_pkg::*;
(
	// crystal-rate clock and system reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// mode controls
	input wire logic synthSource,
	input wire logic fullHalt,
	input wire logic singleChip,
	input wire logic busClkDisable,
	// failure detectors
	input wire logic watchdogFail,
	input wire logic clockMonitorFail,
	// reset pin, open drain
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOe,
	// bus phase clock pin
	output logic busClkOut,
	// status to the core
	output logic coreResetN,
	output logic resetInternal,
	output logic resetClassValid
);
	typedef struct packed {
		logic [PH_W-1:0] phase;
		bcrp_state_t state;
		logic [7:0] cnt;
		logic pinOe;
		logic pinData;
		logic busClk;
		logic coreRstN;
		logic intern;
		logic classValid;
	} bcrp_top_t;
	bcrp_top_t r_q;
	bcrp_top_t r_d;

	// advance a bus-cycle counter on a bus tick, hold it otherwise
	function automatic logic [7:0] count_up(
		input logic [7:0] cnt,
		input logic tick
	);
		return tick ? (cnt + 8'h01) : cnt;
	endfunction : count_up

	// true on the bus tick that closes a span of the given length
	function automatic logic span_done(
		input logic [7:0] cnt,
		input logic [7:0] span,
		input logic tick
	);
		return tick && (cnt == (span - 8'h01));
	endfunction : span_done

	// access half of a bus cycle covers the upper phase counts
	function automatic logic access_phase(
		input logic [PH_W-1:0] ph
	);
		return ph >= PH_HIGH_START;
	endfunction : access_phase

	logic pinSync;
	logic busTick;
	logic pinLow;
	logic failSeen;
	logic busClkGate;
	logic accessHalf;
	logic holdDone;
	logic riseDone;

	// reset pin enters another domain, synchronise it
	bcrp_sync bcrp_sync_i (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.din(resetPinIn),
		.dout(pinSync)
	);

	// one bus cycle completes when phase wraps, and not in full halt
	assign busTick = !fullHalt && (r_q.phase == PH_W'(CRYSTAL_DRIVE_PIN_DIV - 1));

	// synchronised pin held low from outside
	assign pinLow = !pinSync;

	// either detector asks for an internal reset
	assign failSeen = watchdogFail || clockMonitorFail;

	// pin toggles only on the crystal path, outside halt, when not switched off
	assign busClkGate = !fullHalt && !synthSource && !(singleChip && busClkDisable);

	// upper half of the current bus cycle drives the pin high
	assign accessHalf = access_phase(r_q.phase);

	// hold span and rise window both close on a bus tick
	assign holdDone = span_done(r_q.cnt, HOLD_CYCLES, busTick);
	assign riseDone = span_done(r_q.cnt, RISE_CYCLES, busTick);

	// next state
	always_comb
	begin
		r_d = r_q;
		// open-drain data line never drives high
		r_d.pinData = 1'b0;
		// quarter-rate phase counter, frozen in full halt
		if (!fullHalt)
			r_d.phase = r_q.phase + 2'h1;
		// synthesizer source or pin switched off: clock held low
		r_d.busClk = busClkGate && accessHalf;
		case (r_q.state)
			// running, watch the detectors and the pin
			BCRP_RUN:
			begin
				r_d.coreRstN = 1'b1;
				if (failSeen)
				begin
					r_d.state = BCRP_HOLD;
					r_d.pinOe = 1'b1;
					r_d.cnt = CNT_RST;
					r_d.coreRstN = 1'b0;
					r_d.classValid = 1'b0;
				end
				else if (pinLow)
				begin
					r_d.state = BCRP_EXT;
					r_d.coreRstN = 1'b0;
					r_d.classValid = 1'b0;
				end
			end

			// internal reset, pin pulled low for the hold span
			BCRP_HOLD:
			begin
				r_d.cnt = count_up(r_q.cnt, busTick);
				if (holdDone)
				begin
					r_d.pinOe = 1'b0;
					r_d.cnt = CNT_RST;
					r_d.state = BCRP_SAMPLE;
				end
			end

			// pin released, time its rise
			BCRP_SAMPLE:
			begin
				if (pinSync)
				begin
					r_d.intern = 1'b1;
					r_d.classValid = 1'b1;
					r_d.coreRstN = 1'b1;
					r_d.state = BCRP_RUN;
				end
				else
				begin
					r_d.cnt = count_up(r_q.cnt, busTick);
					if (riseDone)
					begin
						r_d.intern = 1'b0;
						r_d.state = BCRP_EXT;
					end
				end
			end

			// external or slow-rising reset
			BCRP_EXT:
			begin
				// stay in reset until the pin is released
				r_d.coreRstN = 1'b0;
				if (pinSync)
				begin
					r_d.intern = 1'b0;
					r_d.classValid = 1'b1;
					r_d.coreRstN = 1'b1;
					r_d.state = BCRP_RUN;
				end
			end

			// unknown code, fall back to running
			default:
			begin
				r_d.state = BCRP_RUN;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk)
	begin
		// start-up values, then hold while the clock enable is low
		if (!rstn)
		begin
			r_q.phase <= PH_RST;
			r_q.state <= BCRP_RUN;
			r_q.cnt <= CNT_RST;
			r_q.pinOe <= 1'b0;
			r_q.pinData <= 1'b0;
			r_q.busClk <= 1'b0;
			r_q.coreRstN <= 1'b0;
			r_q.intern <= 1'b0;
			r_q.classValid <= 1'b0;
		end
		else if (ce)
			r_q <= r_d;
	end

	// open-drain pin data and enable, straight from flops
	assign resetPinOut = r_q.pinData;
	assign resetPinOe = r_q.pinOe;

	// bus phase clock
	assign busClkOut = r_q.busClk;

	// status to the core
	assign coreResetN = r_q.coreRstN;
	assign resetInternal = r_q.intern;
	assign resetClassValid = r_q.classValid;
endmodule : bcrp_top
`default_nettype wire

// File: verif/bcrp_asserts.sv
// port assertions for the bus clock and reset pin block
`default_nettype none
module bcrp_asserts (
	// watched ports
	input wire logic clk,
	input wire logic rstn,
	input wire logic synthSource,
	input wire logic fullHalt,
	input wire logic singleChip,
	input wire logic busClkDisable,
	input wire logic watchdogFail,
	input wire logic clockMonitorFail,
	input wire logic resetPinIn,
	input wire logic resetPinOe,
	input wire logic busClkOut,
	input wire logic coreResetN,
	input wire logic resetInternal,
	input wire logic resetClassValid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	chk_pin_pull: assert property ((watchdogFail || clockMonitorFail) && coreResetN
		&& !resetPinOe |=> resetPinOe && !coreResetN) else $error("pin not pulled");
	chk_core_hold: assert property (!resetPinIn[*5] |-> !coreResetN)
		else $error("core not held");
	chk_bus_period: assert property ((rstn && !fullHalt && !synthSource
		&& !(singleChip && busClkDisable))[*8] |-> busClkOut == $past(busClkOut, 4)
		&& busClkOut != $past(busClkOut, 2)) else $error("bus clock shape");
	chk_halt_stop: assert property (fullHalt[*2] |-> !busClkOut)
		else $error("bus clock in halt");
	chk_pin_off: assert property ((singleChip && busClkDisable)[*2] |-> !busClkOut)
		else $error("bus clock not off");
	chk_synth_low: assert property (synthSource[*2] |-> !busClkOut)
		else $error("bus clock with synth");
	chk_hold_len: assert property ($rose(resetPinOe) |->
		(resetPinOe throughout ##60 1) ##[1:5] !resetPinOe) else $error("hold length");
	chk_class_int: assert property ($fell(resetPinOe) ##0 resetPinIn[*4] |->
		##[1:16] resetInternal && resetClassValid) else $error("not internal");
	chk_valid_clear: assert property ($rose(resetPinOe) |-> !resetClassValid)
		else $error("class still valid");
endmodule : bcrp_asserts
bind bcrp_top bcrp_asserts bcrp_asserts_i (.*);
`default_nettype wire

// File: verif/bcrp_pin_model.sv
// reset pin with pull-up, optional slow rc rise
`default_nettype none
module bcrp_pin_model (
	// pin side
	input wire logic clk,
	input wire logic pull,
	input wire logic slow,
	output logic level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] riseCnt = 6'h00;
	// slow mode keeps the pin low for 40 cycles after release
	always @(posedge clk)
		riseCnt <= pull ? 6'h28 : (riseCnt != 6'h00 ? riseCnt - 6'h01 : 6'h00);
	assign level = !pull && (!slow || riseCnt == 6'h00);
endmodule : bcrp_pin_model
`default_nettype wire

// File: verif/bus_clock_and_reset_pin_tb.sv
// bench for the bus clock and reset pin block
`default_nettype none
module bus_clock_and_reset_pin_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn = 1'h0, synth = 1'h0, halt = 1'h0, single = 1'h0, dis = 1'h0;
	logic wdog = 1'h0, cmon = 1'h0, extLow = 1'h0, slow = 1'h0;
	logic oe, pin, pinOut, busClk, coreN, intern, valid;
	int n_mismatch = 0;
	int tests_run = 0;
	bcrp_pin_model bcrp_pin_model_i (.clk(clk), .pull(oe || extLow), .slow(slow), .level(pin));
	bcrp_top bcrp_top_i (.clk(clk), .rstn(rstn), .ce(1'h1), .synthSource(synth),
		.fullHalt(halt), .singleChip(single), .busClkDisable(dis), .watchdogFail(wdog),
		.clockMonitorFail(cmon), .resetPinIn(pin), .resetPinOut(pinOut), .resetPinOe(oe),
		.busClkOut(busClk), .coreResetN(coreN), .resetInternal(intern), .resetClassValid(valid));
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %b want %b", $time, got, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task close_out;
		$display("compared %0d, wrong %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	// bus clock rises over 40 crystal cycles
	task rises(input int exp);
		int k;
		logic prev;
		k = 0;
		repeat (40)
		begin
			prev = busClk;
			step(1);
			if (busClk === 1'h1 && prev === 1'h0)
				k++;
		end
		chk(k == exp, 1'h1);
	endtask : rises
	// bounded wait for the core to leave reset, then the class
	task settle(input logic expIntern);
		int i;
		for (i = 0; i < 300 && coreN !== 1'h1; i++)
			step(1);
		if (i == 300)
		begin
			n_mismatch++;
			$display("wrong value at %0t: core held in reset", $time);
			close_out();
		end
		else
		begin
			chk(valid, 1'h1);
			chk(intern, expIntern);
		end
	endtask : settle
	task t_clock;
		rises(10);
		dis = 1'h1;
		rises(10);
		single = 1'h1;
		rises(0);
		dis = 1'h0;
		halt = 1'h1;
		rises(0);
		halt = 1'h0;
		synth = 1'h1;
		rises(0);
		synth = 1'h0;
		single = 1'h0;
		$display("clock test over");
	endtask : t_clock
	// failure pulse, pin pulled, then rise time decides the class
	task t_fail(input logic dog, input logic isSlow);
		slow = isSlow;
		wdog = dog;
		cmon = !dog;
		step(1);
		chk(oe, 1'h1);
		chk(coreN, 1'h0);
		chk(pinOut, 1'h0);
		wdog = 1'h0;
		cmon = 1'h0;
		step(57);
		chk(oe, 1'h1);
		settle(!isSlow);
		slow = 1'h0;
		$display("failure test over");
	endtask : t_fail
	task t_ext;
		extLow = 1'h1;
		step(8);
		chk(coreN, 1'h0);
		chk(oe, 1'h0);
		extLow = 1'h0;
		settle(1'h0);
		$display("external test over");
	endtask : t_ext
	initial
	begin
		step(2);
		rstn = 1'h1;
		t_clock();
		t_fail(1'h1, 1'h0);
		t_fail(1'h0, 1'h1);
		t_ext();
		close_out();
	end
endmodule : bus_clock_and_reset_pin_tb
`default_nettype wire
